// ==== hdl/spc_serial_port.sv ====
// Summary of operation
// [RULE_01] echo setting on: every received character is sent back out; characters with a framing or parity error are not echoed
// [RULE_02] echo setting reads as 0 for off, 1 for on
// [RULE_03] port preset turns echo on
// [RULE_04] settings kept across reset and system preset
// [RULE_05] flow control is XON pacing or none only
// [RULE_06] port preset selects no pacing
// [RULE_07] flow control reads back XON or none
// [RULE_08] rear port of two-port variant takes even, odd or none parity
// [RULE_09] other ports also take forced-one parity
// [RULE_10] port preset sets parity to none
// [RULE_11] parity on: 7 data plus parity; off: 8 data bits
// [RULE_12] ports without width choice force 7 bits with even/odd parity
// [RULE_13] parity reads back even, odd, none or forced-one
// [RULE_14] rear port of two-port variant selects 1 or 2 stop bits
// [RULE_15] rear port preset sets one stop bit
// [RULE_16] baud is 1200, 2400, 9600 or 19200; preset picks 9600
// [RULE_17] port preset is a one-shot loading all factory defaults
// [RULE_18] host sends setting changes over the addressed port itself
// [RULE_19] rear port preset honoured only when arriving on rear port
// [RULE_20] last sent response kept and returned on last-response query
// [RULE_21] error queue read pops oldest; kept only in last response
// [RULE_22] rear port of two-port variant selects 7 or 8 data bits
// [RULE_23] forced-one parity sends one and never flags parity errors
// [RULE_24] XON pacing: pause on 0x13, resume on 0x11
//
// Implementation choices: the register addresses and the plain strobed port.
`default_nettype none
`include "spc_cfg.svh"
module spc_serial_port #(
    parameter bit REAR_SELECTABLE = 1'b1
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    input  wire logic       cmdOnThisPort,
    input  wire logic       serialRx,
    output logic [7:0]      regRdata,
    output logic            serialTx
);
    // ****************************************
    // configuration
    // ****************************************
    spc_pkg::spc_cfg_s cfg;
    spc_pkg::spc_par_e reqPar;
    logic              cfgWrite;
    logic              presetWrite;
    logic              parOn;
    logic              use8;
    logic              useStop2;

    assign cfgWrite    = regWr && regAddr == `SPC_ADDR_CTRL
                         && cmdOnThisPort; // RULE_18
    assign presetWrite = regWr && regAddr == `SPC_ADDR_PRESET
                         && cmdOnThisPort && regWdata[0]; // RULE_19
    assign reqPar = spc_pkg::spc_par_e'(
        regWdata[`SPC_CTRL_PAR_HI:`SPC_CTRL_PAR_LO]);

    // cfg has no reset term: stands in for non-volatile storage
    always_ff @(posedge clk_sys) begin // RULE_04
        if (presetWrite) begin // RULE_17
            cfg.echo   <= `SPC_DEF_ECHO; // RULE_03
            cfg.flow_control_setting   <= `SPC_DEF_FLOW_CONTROL_SETTING; // RULE_06
            cfg.parity <= spc_pkg::spc_par_e'(`SPC_DEF_PAR); // RULE_10
            cfg.bits8  <= `SPC_DEF_BITS8;
            cfg.stop2  <= `SPC_DEF_STOP2; // RULE_15
            cfg.baud   <= spc_pkg::spc_baud_e'(`SPC_DEF_BAUD); // RULE_16
        end else if (cfgWrite) begin
            cfg.echo <= regWdata[`SPC_CTRL_ECHO];
            cfg.flow_control_setting <= regWdata[`SPC_CTRL_FLOW_CONTROL_SETTING]; // RULE_05
            if (!(REAR_SELECTABLE && reqPar == spc_pkg::SPC_PAR_ONE)) begin
                cfg.parity <= reqPar; // RULE_08 RULE_09
            end
            if (REAR_SELECTABLE) begin
                cfg.bits8 <= regWdata[`SPC_CTRL_BITS8]; // RULE_22
                cfg.stop2 <= regWdata[`SPC_CTRL_STOP2]; // RULE_14
            end
            cfg.baud <= spc_pkg::spc_baud_e'(
                regWdata[`SPC_CTRL_BAUD_HI:`SPC_CTRL_BAUD_LO]); // RULE_16
        end
    end

    assign parOn    = cfg.parity != spc_pkg::SPC_PAR_NONE;
    // fixed-width ports follow parity; rear port uses its own width only while parity is none
    assign use8     = REAR_SELECTABLE ? (cfg.bits8 && !parOn)
                                      : !parOn; // RULE_11 RULE_12
    assign useStop2 = REAR_SELECTABLE && cfg.stop2;

    function automatic logic parBit(input logic [6:0] d,
                                    input spc_pkg::spc_par_e p);
        case (p)
            spc_pkg::SPC_PAR_EVEN: parBit = ^d;
            spc_pkg::SPC_PAR_ODD:  parBit = ~^d;
            default:               parBit = 1'b1; // RULE_23
        endcase
    endfunction

    // ****************************************
    // receiver
    // ****************************************
    logic       rxMeta;
    logic       rxSync;
    logic       rxBusy;
    logic [3:0] rxIdx;
    logic [8:0] rxShift;
    logic       rxTick;
    logic       rxHalf;
    logic       rxStart;
    logic       rxDone;
    logic [3:0] rxLast;
    logic [7:0] rxChar;
    logic       rxParErr;
    logic       rxFrameErr;
    logic [7:0] rxData;
    logic       rxValid;
    logic [7:0] rxPay;
    logic       rxErrNow;

    always_ff @(posedge clk_sys) begin
        rxMeta <= serialRx;
        rxSync <= rxMeta;
    end

    assign rxStart = !rxBusy && !rxSync;
    assign rxLast  = 4'd8; // data bits plus parity slot always 8
    spc_baud_gen rxBaud (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .restart  (rxStart),
        .baud     (cfg.baud),
        .tick     (rxTick),
        .halfTick (rxHalf)
    );

    // samples at bit centres: index 0 start, 1..8 payload, 9 stop
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rxBusy  <= 1'b0;
            rxIdx   <= 4'h0;
            rxShift <= 9'h0;
        end else if (rxStart) begin
            rxBusy <= 1'b1;
            rxIdx  <= 4'h0;
        end else if (rxBusy && rxHalf) begin
            if (rxIdx == 4'h0 && rxSync) begin
                rxBusy <= 1'b0;
            end else begin
                rxShift <= {rxSync, rxShift[8:1]};
                rxIdx   <= rxIdx + 4'h1;
                if (rxIdx == rxLast + 4'h1) begin
                    rxBusy <= 1'b0;
                end
            end
        end
    end

    assign rxDone = rxBusy && rxHalf && rxIdx == rxLast + 4'h1;
    // stop not yet shifted in at rxDone: payload sits above the start bit
    assign rxPay  = rxShift[8:1];
    assign rxChar = use8 ? rxPay : {1'b0, rxPay[6:0]}; // RULE_11
    assign rxParErr = parOn && cfg.parity != spc_pkg::SPC_PAR_ONE
        && rxPay[7] != parBit(rxPay[6:0], cfg.parity); // RULE_23
    assign rxErrNow = !rxSync || rxParErr;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            rxData     <= 8'h0;
            rxValid    <= 1'b0;
            rxFrameErr <= 1'b0;
        end else if (rxDone) begin
            rxData     <= rxChar;
            rxValid    <= 1'b1;
            rxFrameErr <= rxErrNow;
        end else if (regRd && regAddr == `SPC_ADDR_RXDATA) begin
            rxValid <= 1'b0;
        end
    end

    // ****************************************
    // pacing and echo
    // ****************************************
    logic paused;
    logic echoPend;

    always_ff @(posedge clk_sys) begin
        if (!reset_n || !cfg.flow_control_setting) begin
            paused <= 1'b0;
        end else if (rxDone && rxChar == `SPC_XOFF) begin
            paused <= 1'b1; // RULE_24
        end else if (rxDone && rxChar == `SPC_XON) begin
            paused <= 1'b0; // RULE_24
        end
    end

    // ****************************************
    // transmitter
    // ****************************************
    logic       txBusy;
    logic [3:0] txIdx;
    logic [3:0] txEnd;
    logic [8:0] txFrame;
    logic [7:0] txPend;
    logic       txPendValid;
    logic       txTick;
    logic       txLoad;
    logic [7:0] echoChar;
    logic [7:0] lastResp;
    logic [7:0] errHead;
    logic       txWrite;

    assign txEnd   = useStop2 ? 4'd10 : 4'd9;
    assign txLoad  = !txBusy && (echoPend || txPendValid) && !paused;
    assign txWrite = regWr && regAddr == `SPC_ADDR_TXDATA && !txPendValid;

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            echoPend <= 1'b0;
            echoChar <= 8'h0;
        end else if (rxDone && cfg.echo && !rxErrNow) begin
            echoPend <= 1'b1; // RULE_01
            echoChar <= rxChar;
        end else if (txLoad) begin
            echoPend <= 1'b0;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            txPend      <= 8'h0;
            txPendValid <= 1'b0;
        end else if (txWrite) begin
            txPend      <= regWdata;
            txPendValid <= 1'b1;
        end else if (txLoad && !echoPend) begin
            txPendValid <= 1'b0;
        end
    end

    // last response: every software-sent item is remembered
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            lastResp <= 8'h0;
        end else if (txWrite) begin
            lastResp <= regWdata; // RULE_20
        end else if (regRd && regAddr == `SPC_ADDR_ERRQ) begin
            lastResp <= errHead; // RULE_21
        end
    end

    spc_baud_gen txBaud (
        .clk_sys  (clk_sys),
        .reset_n  (reset_n),
        .restart  (txLoad),
        .baud     (cfg.baud),
        .tick     (txTick),
        .halfTick ()
    );

    function automatic logic [8:0] frameOf(input logic [7:0] c);
        frameOf = use8 ? {1'b1, c}
                       : {1'b1, parBit(c[6:0], cfg.parity), c[6:0]}; // RULE_11
    endfunction

    // start bit driven on load; busy holds through the last stop bit
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            txBusy   <= 1'b0;
            txIdx    <= 4'h0;
            txFrame  <= 9'h1ff;
            serialTx <= 1'b1;
        end else if (txLoad) begin
            txBusy   <= 1'b1;
            txIdx    <= 4'h0;
            txFrame  <= frameOf(echoPend ? echoChar : txPend);
            serialTx <= 1'b0;
        end else if (txBusy && txTick) begin
            txIdx <= txIdx + 4'h1;
            if (txIdx == txEnd) begin
                txBusy <= 1'b0; // RULE_14
            end
            serialTx <= txIdx < 4'd8 ? txFrame[txIdx[2:0]] : 1'b1;
        end
    end

    // ****************************************
    // error queue
    // ****************************************
    logic [7:0] errMem [`SPC_ERRQ_DEPTH];
    logic [1:0] errRd;
    logic [1:0] errWr;
    logic [2:0] errCount;
    logic       errPush;
    logic       errPop;

    assign errHead = errCount == 3'h0 ? 8'h0 : errMem[errRd];
    assign errPush = regWr && regAddr == `SPC_ADDR_ERRPUSH
                     && errCount != 3'(`SPC_ERRQ_DEPTH);
    assign errPop  = regRd && regAddr == `SPC_ADDR_ERRQ && errCount != 3'h0;

    always_ff @(posedge clk_sys) begin
        if (errPush) begin
            errMem[errWr] <= regWdata;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            errRd    <= 2'h0;
            errWr    <= 2'h0;
            errCount <= 3'h0;
        end else begin
            if (errPush) begin
                errWr <= errWr + 2'h1;
            end
            if (errPop) begin
                errRd <= errRd + 2'h1; // RULE_21
            end
            errCount <= errCount + 3'(errPush) - 3'(errPop);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            regRdata <= 8'h0;
        end else if (!regRd) begin
            regRdata <= 8'h0;
        end else if (regAddr == `SPC_ADDR_CTRL) begin
            regRdata <= {cfg.baud, useStop2, use8, cfg.parity,
                         cfg.flow_control_setting, cfg.echo}; // RULE_02 RULE_07 RULE_13
        end else if (regAddr == `SPC_ADDR_RXDATA) begin
            regRdata <= rxData;
        end else if (regAddr == `SPC_ADDR_STATUS) begin
            regRdata <= {2'h0, errCount == 3'h0, paused, rxFrameErr,
                         txPendValid, txBusy, rxValid};
        end else if (regAddr == `SPC_ADDR_LASTRSP) begin
            regRdata <= lastResp; // RULE_20
        end else if (regAddr == `SPC_ADDR_ERRQ) begin
            regRdata <= errHead;
        end else begin
            regRdata <= 8'h0;
        end
    end
endmodule // spc_serial_port
`default_nettype wire

// ==== hdl/spc_cfg.svh ====
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// register offsets
`define SPC_ADDR_CTRL    8'h00
`define SPC_ADDR_PRESET  8'h04
`define SPC_ADDR_TXDATA  8'h08
`define SPC_ADDR_RXDATA  8'h0c
`define SPC_ADDR_STATUS  8'h10
`define SPC_ADDR_LASTRSP 8'h14
`define SPC_ADDR_ERRQ    8'h18
`define SPC_ADDR_ERRPUSH 8'h1c
// control field positions
`define SPC_CTRL_ECHO    0
`define SPC_CTRL_FLOW_CONTROL_SETTING    1
`define SPC_CTRL_PAR_LO  2
`define SPC_CTRL_PAR_HI  3
`define SPC_CTRL_BITS8   4
`define SPC_CTRL_STOP2   5
`define SPC_CTRL_BAUD_LO 6
`define SPC_CTRL_BAUD_HI 7
// factory defaults
`define SPC_DEF_ECHO     1'b1
`define SPC_DEF_FLOW_CONTROL_SETTING     1'b0
`define SPC_DEF_PAR      2'h0
`define SPC_DEF_BITS8    1'b1
`define SPC_DEF_STOP2    1'b0
`define SPC_DEF_BAUD     2'h2
// timing
`define SPC_CLK_HZ       10000000
`define SPC_DIV_1200     (`SPC_CLK_HZ / 1200)
`define SPC_DIV_2400     (`SPC_CLK_HZ / 2400)
`define SPC_DIV_9600     (`SPC_CLK_HZ / 9600)
`define SPC_DIV_19200    (`SPC_CLK_HZ / 19200)
// flow characters and error queue depth
`define SPC_XON          8'h11
`define SPC_XOFF         8'h13
`define SPC_ERRQ_DEPTH   4
`endif

// ==== hdl/spc_pkg.sv ====
`default_nettype none
package spc_pkg;
    typedef enum logic [1:0] {
        SPC_PAR_NONE = 2'b00,
        SPC_PAR_EVEN = 2'b01,
        SPC_PAR_ODD  = 2'b10,
        SPC_PAR_ONE  = 2'b11
    } spc_par_e;
    typedef enum logic [1:0] {
        SPC_BAUD_1200  = 2'b00,
        SPC_BAUD_2400  = 2'b01,
        SPC_BAUD_9600  = 2'b10,
        SPC_BAUD_19200 = 2'b11
    } spc_baud_e;
    typedef struct packed {
        spc_baud_e baud;
        logic      stop2;
        logic      bits8;
        spc_par_e  parity;
        logic      flow_control_setting;
        logic      echo;
    } spc_cfg_s;
    typedef struct packed {
        logic       addrErr;
        logic [7:0] data;
    } spc_rx_s;
endpackage
`default_nettype wire

// ==== hdl/spc_baud_gen.sv ====
`default_nettype none
`include "spc_cfg.svh"
module spc_baud_gen (
    input  wire logic              clk_sys,
    input  wire logic              reset_n,
    input  wire logic              restart,
    input  wire spc_pkg::spc_baud_e baud,
    output logic                   tick,
    output logic                   halfTick
);
    logic [13:0] count;
    logic [13:0] period;

    always_comb begin
        case (baud)
            spc_pkg::SPC_BAUD_1200: period = 14'(`SPC_DIV_1200);
            spc_pkg::SPC_BAUD_2400: period = 14'(`SPC_DIV_2400);
            spc_pkg::SPC_BAUD_9600: period = 14'(`SPC_DIV_9600);
            default:                period = 14'(`SPC_DIV_19200);
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n || restart || tick) begin
            count <= 14'h0;
        end else begin
            count <= count + 14'h1;
        end
    end

    assign tick     = (count == period - 14'h1);
    assign halfTick = (count == (period >> 1));
endmodule // spc_baud_gen
`default_nettype wire

// ==== test/spc_serial_port_monitor.sv ====
`default_nettype none
`include "spc_cfg.svh"
module spc_serial_port_monitor #(
    parameter bit REAR_SELECTABLE = 1'b1
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWr,
    input wire logic       regRd,
    input wire logic       cmdOnThisPort,
    input wire logic       serialRx,
    input wire logic [7:0] regRdata,
    input wire logic       serialTx
);
    // ****************
    // port checks
    // ****************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_rdata_idle_zero: assert property (!regRd |=> regRdata == 8'h00)
        else $error("read data not zero outside read");
    a_echo_flow_control_setting_rb: assert property ((regWr && regAddr == `SPC_ADDR_CTRL
        && cmdOnThisPort) ##1 (regRd && regAddr == `SPC_ADDR_CTRL) |=>
        (regRdata & 8'h03) == ($past(regWdata, 2) & 8'h03))
        else $error("echo or pacing read back wrong");
    a_cfg_refused: assert property ((regRd && regAddr == `SPC_ADDR_CTRL)
        ##1 (regWr && regAddr == `SPC_ADDR_CTRL && !cmdOnThisPort)
        ##1 (regRd && regAddr == `SPC_ADDR_CTRL) |=>
        regRdata == $past(regRdata, 2))
        else $error("config taken from other port");
    a_preset_dflt: assert property ((regWr && regAddr == `SPC_ADDR_PRESET
        && cmdOnThisPort && regWdata[0]) ##1
        (regRd && regAddr == `SPC_ADDR_CTRL) |=> regRdata == 8'h91)
        else $error("preset defaults wrong");
    a_preset_ignored: assert property ((regRd && regAddr == `SPC_ADDR_CTRL)
        ##1 (regWr && regAddr == `SPC_ADDR_PRESET && !cmdOnThisPort)
        ##1 (regRd && regAddr == `SPC_ADDR_CTRL) |=>
        regRdata == $past(regRdata, 2))
        else $error("preset taken from other port");
    a_par_one_refused: assert property ((regRd && regAddr == `SPC_ADDR_CTRL)
        ##1 (regWr && regAddr == `SPC_ADDR_CTRL && regWdata[3:2] == 2'b11
        && REAR_SELECTABLE) ##1 (regRd && regAddr == `SPC_ADDR_CTRL) |=>
        (regRdata & 8'h0c) == ($past(regRdata, 2) & 8'h0c))
        else $error("forced one parity taken");
    a_start_bit_held: assert property ($fell(serialTx) |->
        !serialTx [*8])
        else $error("start bit too short");
    a_last_rsp: assert property ((regRd && regAddr == `SPC_ADDR_ERRQ)
        ##1 (regRd && regAddr == `SPC_ADDR_LASTRSP) |=>
        regRdata == $past(regRdata))
        else $error("last response differs from popped entry");
endmodule // spc_serial_port_monitor
bind spc_serial_port spc_serial_port_monitor #(
    .REAR_SELECTABLE(REAR_SELECTABLE)
) spc_serial_port_monitor_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .cmdOnThisPort(cmdOnThisPort), .serialRx(serialRx),
    .regRdata(regRdata), .serialTx(serialTx)
);
`default_nettype wire

// ==== test/spc_host_model.sv ====
`default_nettype none
module spc_host_model #(
    parameter int BIT = 520
) (
    input  wire logic       clk_sys,
    input  wire logic       serialTx,
    output var logic        serialRx,
    output var logic [7:0]  rxByte,
    output var logic [7:0]  rxCount
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        serialRx = 1'b1;
        rxByte = 8'h00;
        rxCount = 8'h00;
    end
    // ****************
    // host transmit and receive
    // ****************
    task automatic send(input logic [7:0] b);
        serialRx <= 1'b0;
        repeat (BIT) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            serialRx <= b[i];
            repeat (BIT) @(posedge clk_sys);
        end
        serialRx <= 1'b1;
        repeat (BIT) @(posedge clk_sys);
    endtask
    always begin
        @(negedge serialTx);
        repeat (BIT / 2) @(posedge clk_sys);
        if (!serialTx) begin
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk_sys);
                rxByte[i] = serialTx;
            end
            repeat (BIT) @(posedge clk_sys);
            rxCount = rxCount + 8'h01;
        end
    end
endmodule // spc_host_model
`default_nettype wire

// ==== test/spc_serial_port_tb_top.sv ====
`default_nettype none
`include "spc_cfg.svh"
module spc_serial_port_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int BIT = `SPC_DIV_19200;
    logic       clk_sys, reset_n, regWr, regRd, cmdOnThisPort;
    logic       serialRx, serialTx, serialRxF, serialTxF;
    logic [7:0] regAddr, regWdata, regRdata, prev, rxByte, rxCount, c;
    logic [7:0] frontRdata, prevF, rxByteF, rxCountF;
    int         failures, cmp_count;
    spc_serial_port #(.REAR_SELECTABLE(1'b1)) spc_serial_port_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .cmdOnThisPort(cmdOnThisPort), .serialRx(serialRx),
        .regRdata(regRdata), .serialTx(serialTx));
    spc_host_model #(.BIT(BIT)) spc_host_model_i (
        .clk_sys(clk_sys), .serialTx(serialTx), .serialRx(serialRx),
        .rxByte(rxByte), .rxCount(rxCount));
    spc_serial_port #(.REAR_SELECTABLE(1'b0)) spc_serial_port_front_i (
        .clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .cmdOnThisPort(cmdOnThisPort), .serialRx(serialRxF),
        .regRdata(frontRdata), .serialTx(serialTxF));
    spc_host_model #(.BIT(BIT)) spc_host_model_front_i (
        .clk_sys(clk_sys), .serialTx(serialTxF), .serialRx(serialRxF),
        .rxByte(rxByteF), .rxCount(rxCountF));
    always #50 clk_sys = ~clk_sys;
    // ****************
    // access tasks
    // ****************
    task automatic bus(input logic w, r, input logic [7:0] a, d);
        regWr <= w;
        regRd <= r;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk_sys);
        prev = regRdata;
        prevF = frontRdata;
    endtask
    task automatic chk(input string nm, input logic [7:0] e, g);
        cmp_count++;
        if (g !== e) begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a, e, input string nm);
        bus(1'b0, 1'b1, a, 8'h00);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        chk(nm, e, prev);
    endtask
    task automatic wait_rx();
        int k;
        k = 0;
        while (rxCount === c && k < 30000) begin
            @(posedge clk_sys);
            k++;
        end
        if (k == 30000) failures++;
    endtask
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk_sys);
        failures++;
        summarize();
    end
    // ****************
    // tests
    // ****************
    initial begin
        clk_sys = 1'b0;
        reset_n = 1'b0;
        {regWr, regRd, regAddr, regWdata} = '0;
        cmdOnThisPort = 1'b1;
        repeat (5) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        bus(1'b1, 1'b0, `SPC_ADDR_PRESET, 8'h01);
        rd(`SPC_ADDR_CTRL, 8'h91, "preset defaults");
        $display("test preset done");
        bus(1'b1, 1'b0, `SPC_ADDR_CTRL, 8'hd3);
        cmdOnThisPort <= 1'b0;
        bus(1'b0, 1'b1, `SPC_ADDR_CTRL, 8'h00);
        bus(1'b1, 1'b0, `SPC_ADDR_CTRL, 8'h00);
        bus(1'b0, 1'b1, `SPC_ADDR_CTRL, 8'h00);
        bus(1'b1, 1'b0, `SPC_ADDR_PRESET, 8'h01);
        rd(`SPC_ADDR_CTRL, 8'hd3, "ctrl other port");
        reset_n <= 1'b0;
        repeat (5) bus(1'b0, 1'b0, 8'h00, 8'h00);
        reset_n <= 1'b1;
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        rd(`SPC_ADDR_CTRL, 8'hd3, "ctrl after reset");
        $display("test refusal and retention done");
        cmdOnThisPort <= 1'b1;
        bus(1'b0, 1'b1, `SPC_ADDR_CTRL, 8'h00);
        bus(1'b1, 1'b0, `SPC_ADDR_CTRL, 8'hdd);
        rd(`SPC_ADDR_CTRL, 8'hd1, "forced one refused");
        chk("front forced one", 8'hcd, prevF);
        $display("test parity choice done");
        c = rxCount;
        spc_host_model_i.send(8'h5a);
        wait_rx();
        chk("echo char", 8'h5a, rxByte);
        rd(`SPC_ADDR_RXDATA, 8'h5a, "rx data");
        bus(1'b1, 1'b0, `SPC_ADDR_CTRL, 8'hd0);
        rd(`SPC_ADDR_CTRL, 8'hd0, "echo off read");
        c = rxCount;
        spc_host_model_i.send(8'h3c);
        repeat (12 * BIT) @(posedge clk_sys);
        chk("echo off count", c, rxCount);
        $display("test echo done");
        bus(1'b1, 1'b0, `SPC_ADDR_CTRL, 8'hc4);
        bus(1'b1, 1'b0, `SPC_ADDR_TXDATA, 8'h31);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        wait_rx();
        chk("tx even parity", 8'hb1, rxByte);
        chk("front tx parity", 8'hb1, rxByteF);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        chk("front tx count", 8'h01, rxCountF);
        $display("test parity framing done");
        bus(1'b1, 1'b0, `SPC_ADDR_ERRPUSH, 8'h21);
        bus(1'b1, 1'b0, `SPC_ADDR_ERRPUSH, 8'h22);
        bus(1'b0, 1'b1, `SPC_ADDR_ERRQ, 8'h00);
        bus(1'b0, 1'b1, `SPC_ADDR_LASTRSP, 8'h00);
        chk("errq oldest", 8'h21, prev);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        chk("last response", 8'h21, prev);
        rd(`SPC_ADDR_ERRQ, 8'h22, "errq next");
        rd(8'h20, 8'h00, "unmapped read");
        $display("test last response done");
        bus(1'b1, 1'b0, `SPC_ADDR_CTRL, 8'hd2);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        c = rxCount;
        spc_host_model_i.send(`SPC_XOFF);
        rd(`SPC_ADDR_STATUS, 8'h31, "status paused");
        bus(1'b1, 1'b0, `SPC_ADDR_TXDATA, 8'h41);
        bus(1'b0, 1'b0, 8'h00, 8'h00);
        repeat (3 * BIT) @(posedge clk_sys);
        chk("paused count", c, rxCount);
        spc_host_model_i.send(`SPC_XON);
        wait_rx();
        chk("resumed char", 8'h41, rxByte);
        $display("test pacing done");
        summarize();
    end
endmodule // spc_serial_port_tb_top
`default_nettype wire
